// ==== spa_defines.vh ====
// Constants for the speed point positioning axis sequencer.
`ifndef SPA_DEFINES_VH
`define SPA_DEFINES_VH
`define SPA_PAT_E 2'h0
`define SPA_PAT_P 2'h1
`define SPA_PAT_C 2'h2
`define SPA_PAT_J 2'h3
`define SPA_ST_IDLE 3'h0
`define SPA_ST_ACC 3'h1
`define SPA_ST_RUN 3'h2
`define SPA_ST_DEC 3'h3
`define SPA_ST_STOP 3'h4
`define SPA_SPD_W 16
`define SPA_MOV_W 16
`define SPA_TIM_W 16
`define SPA_TBL_W 8
`define SPA_REQ_AXIS 3'h0
`define SPA_SPD_MAX 16'hFFF0
`define SPA_TIM_MAX 16'h2710
`define SPA_ERR_SET 2'h1
`define SPA_ERR_LIM 2'h2
`define SPA_ERR_CHAIN 2'h3
`endif

// ==== spa_edge.v ====
// Rising edge detector used for start and speed change contacts.
`timescale 1ns/1ps
`default_nettype none
module spa_edge (
  input wire core_clk,
  input wire rst_n,
  input wire level,
  output wire rise
);
  reg prev_r;

  // Previous sample of the level; a held level gives one pulse only.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= level;
    end
  end

  assign rise = level & ~prev_r;
endmodule // spa_edge
`default_nettype wire

// ==== spa_axis.v ====
// Single-axis positioning sequencer with speed point operation.
`timescale 1ns/1ps
`default_nettype none
`include "spa_defines.vh"
module spa_axis (
  input wire core_clk,
  input wire rst_n,
  input wire axis_positioning_start,
  input wire other_op_start,
  input wire interp_mode,
  input wire speed_point_positioning_start,
  input wire [7:0] speed_change_req_word,
  input wire [`SPA_TBL_W-1:0] start_table_num,
  input wire [1:0] tbl_pattern,
  input wire tbl_last,
  input wire tbl_reverse,
  input wire [`SPA_MOV_W-1:0] tbl_move,
  input wire [`SPA_TIM_W-1:0] tbl_acc_time,
  input wire [`SPA_TIM_W-1:0] tbl_dec_time,
  input wire [`SPA_SPD_W-1:0] tbl_speed,
  input wire [`SPA_SPD_W-1:0] axp_speed,
  input wire limit_pos,
  input wire limit_neg,
  input wire error_clear,
  output reg axis_busy_flag,
  output reg axis_operation_done_flag,
  output reg error_notify_flag,
  output reg [1:0] error_code,
  output reg [`SPA_TBL_W-1:0] table_index,
  output reg [`SPA_SPD_W-1:0] cmd_speed,
  output reg [`SPA_SPD_W-1:0] target_speed,
  output reg [`SPA_MOV_W-1:0] move_left,
  output reg moving_reverse
);
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg pend_r;
  reg jmode_r;
  reg last_r;
  reg [`SPA_SPD_W-1:0] step_r;
  wire jstart_rise;
  wire chg_rise;

  // Range check used for both acceleration and deceleration times.
  function time_ok;
    input [`SPA_TIM_W-1:0] t;
    begin
      time_ok = (t != {`SPA_TIM_W{1'b0}}) && (t <= `SPA_TIM_MAX);
    end
  endfunction

  // Speed ramp step derived from speed and time; never zero.
  function [`SPA_SPD_W-1:0] ramp_step;
    input [`SPA_SPD_W-1:0] spd;
    input [`SPA_TIM_W-1:0] t;
    reg [`SPA_SPD_W-1:0] q;
    begin
      q = (t == {`SPA_TIM_W{1'b0}}) ? spd : spd / t;
      ramp_step = (q == {`SPA_SPD_W{1'b0}}) ? {{(`SPA_SPD_W-1){1'b0}}, 1'b1}
                                            : q;
    end
  endfunction

  // Each axis owns its start contact and bit of the request word.
  spa_edge u_jstart (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(speed_point_positioning_start),
    .rise(jstart_rise)
  );
  spa_edge u_chg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .level(speed_change_req_word[`SPA_REQ_AXIS]),
    .rise(chg_rise)
  );

  wire params_ok = (tbl_move != {`SPA_MOV_W{1'b0}}) &&
                   time_ok(tbl_acc_time) && time_ok(tbl_dec_time) &&
                   (tbl_speed != {`SPA_SPD_W{1'b0}}) &&
                   (tbl_speed <= `SPA_SPD_MAX);
  wire limit_any = limit_pos | limit_neg;
  wire limit_run = moving_reverse ? limit_neg : limit_pos;
  wire jbad = (tbl_pattern == `SPA_PAT_J) && interp_mode;
  wire chain_bad = tbl_last && (tbl_pattern != `SPA_PAT_E);
  wire idle = (state_r == `SPA_ST_IDLE);
  wire start_ok = idle && axis_positioning_start && !error_notify_flag;
  wire at_speed = (state_r == `SPA_ST_RUN);
  wire end_reach = (move_left <= cmd_speed) && !jmode_r; // distance per tick

  // Next state of the motion sequencer.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `SPA_ST_IDLE: begin
        if (start_ok && !limit_any && params_ok && !jbad && !chain_bad) begin
          state_nxt = `SPA_ST_ACC;
        end
      end
      `SPA_ST_ACC: begin
        if (limit_run) begin
          state_nxt = `SPA_ST_STOP;
        end else if (cmd_speed == target_speed) begin
          state_nxt = `SPA_ST_RUN;
        end else if (end_reach) begin
          state_nxt = `SPA_ST_DEC;
        end
      end
      `SPA_ST_RUN: begin
        if (limit_run) begin
          state_nxt = `SPA_ST_STOP;
        end else if (cmd_speed != target_speed) begin
          state_nxt = `SPA_ST_ACC;
        end else if (end_reach && last_r) begin
          state_nxt = `SPA_ST_DEC;
        end
      end
      `SPA_ST_DEC, `SPA_ST_STOP: begin
        if (cmd_speed == {`SPA_SPD_W{1'b0}}) begin
          state_nxt = `SPA_ST_IDLE;
        end
      end
      default: begin
        state_nxt = `SPA_ST_IDLE;
      end
    endcase
  end

  // Flags, table stepping and speed profile.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= `SPA_ST_IDLE;
      pend_r <= 1'b0;
      jmode_r <= 1'b0;
      last_r <= 1'b0;
      step_r <= {`SPA_SPD_W{1'b0}};
      axis_busy_flag <= 1'b0;
      axis_operation_done_flag <= 1'b0;
      error_notify_flag <= 1'b0;
      error_code <= 2'h0;
      table_index <= {`SPA_TBL_W{1'b0}};
      cmd_speed <= {`SPA_SPD_W{1'b0}};
      target_speed <= {`SPA_SPD_W{1'b0}};
      move_left <= {`SPA_MOV_W{1'b0}};
      moving_reverse <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Error clear loses to a new error in the same cycle.
      if (error_clear) begin
        error_notify_flag <= 1'b0;
        error_code <= 2'h0;
      end
      if (start_ok) begin
        if (limit_any) begin
          error_notify_flag <= 1'b1;
          error_code <= `SPA_ERR_LIM;
        end else if (!params_ok || jbad) begin
          error_notify_flag <= 1'b1;
          error_code <= `SPA_ERR_SET;
        end else if (chain_bad) begin
          error_notify_flag <= 1'b1;
          error_code <= `SPA_ERR_CHAIN;
        end else begin
          axis_busy_flag <= 1'b1;
          axis_operation_done_flag <= 1'b0;
          table_index <= start_table_num;
          target_speed <= tbl_speed;
          move_left <= tbl_move;
          moving_reverse <= tbl_reverse;
          jmode_r <= (tbl_pattern == `SPA_PAT_J);
          last_r <= tbl_last;
          step_r <= ramp_step(tbl_speed, tbl_acc_time);
          pend_r <= 1'b0;
        end
      end else if (idle && other_op_start) begin
        // Jog, home return and pulser runs are timed elsewhere.
        axis_operation_done_flag <= 1'b0;
      end
      if ((state_r == `SPA_ST_ACC || state_r == `SPA_ST_RUN) && limit_run) begin
        error_notify_flag <= 1'b1;
        error_code <= `SPA_ERR_LIM;
        target_speed <= {`SPA_SPD_W{1'b0}};
      end
      // Speed ramp toward target, or toward zero in deceleration and stop, one step per cycle.
      if (!idle) begin
        if (state_r == `SPA_ST_DEC || state_r == `SPA_ST_STOP) begin
          cmd_speed <= (cmd_speed > step_r) ? cmd_speed - step_r
                                            : {`SPA_SPD_W{1'b0}};
        end else if (cmd_speed < target_speed) begin
          cmd_speed <= (target_speed - cmd_speed > step_r) ?
                       cmd_speed + step_r : target_speed;
        end else if (cmd_speed > target_speed) begin
          cmd_speed <= (cmd_speed - target_speed > step_r) ?
                       cmd_speed - step_r : target_speed;
        end
        if (!jmode_r) begin
          move_left <= (move_left > cmd_speed) ? move_left - cmd_speed
                                               : {`SPA_MOV_W{1'b0}};
        end
      end
      // Edges outside a speed point table are dropped.
      if (chg_rise && jmode_r && !idle) begin
        pend_r <= 1'b1;
      end
      if (pend_r && at_speed && !limit_run) begin
        target_speed <= axp_speed;
        pend_r <= 1'b0;
      end
      // Held at target speed until the start contact moves to the next table.
      if (jmode_r && jstart_rise && !idle) begin
        jmode_r <= 1'b0;
        pend_r <= 1'b0;
        table_index <= table_index + {{(`SPA_TBL_W-1){1'b0}}, 1'b1};
        target_speed <= tbl_speed;
        move_left <= tbl_move;
        last_r <= 1'b1;
      end
      if (!idle && state_nxt == `SPA_ST_IDLE) begin
        axis_busy_flag <= 1'b0;
        axis_operation_done_flag <= 1'b1;
        jmode_r <= 1'b0;
      end
    end
  end
endmodule // spa_axis
`default_nettype wire

// ==== spa_axis_asserts.sv ====
// Port assertions for the speed point axis sequencer.
`timescale 1ns/1ps
`default_nettype none
module spa_axis_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic axis_positioning_start,
  input wire logic other_op_start,
  input wire logic limit_pos,
  input wire logic limit_neg,
  input wire logic moving_reverse,
  input wire logic axis_busy_flag,
  input wire logic axis_operation_done_flag,
  input wire logic error_notify_flag,
  input wire logic [1:0] error_code
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // A start the idle axis can take; refusals must not raise busy.
  wire go = axis_positioning_start & ~axis_busy_flag & ~error_notify_flag;
  a_busy_cause: assert property (
    $rose(axis_busy_flag) |-> $past(axis_positioning_start))
    else $error("busy rose alone");
  a_done_clear: assert property (
    $rose(axis_busy_flag) |-> !axis_operation_done_flag)
    else $error("done kept");
  a_other_clear: assert property (
    other_op_start && !axis_busy_flag |=> !axis_operation_done_flag)
    else $error("done kept");
  a_done_set: assert property (
    $fell(axis_busy_flag) && !error_notify_flag |-> axis_operation_done_flag)
    else $error("done not set");
  a_done_hold: assert property (
    axis_operation_done_flag && !axis_positioning_start && !other_op_start
    |=> axis_operation_done_flag) else $error("done dropped");
  a_limit_refuse: assert property (
    go && (limit_pos || limit_neg) |=> error_notify_flag
    && error_code == 2'h2 && !axis_busy_flag) else $error("limit start");
  a_refuse_quiet: assert property (
    $rose(error_notify_flag) && !$past(axis_busy_flag) |-> !axis_busy_flag)
    else $error("busy on refusal");
  a_limit_stop: assert property (
    axis_busy_flag && !moving_reverse && limit_pos
    |-> ##[1:2] error_notify_flag && error_code == 2'h2)
    else $error("limit run");
  cover property ($rose(axis_busy_flag));
  cover property ($fell(axis_busy_flag) && axis_operation_done_flag);
  cover property ($rose(error_notify_flag) && axis_busy_flag);
endmodule // spa_axis_asserts
`default_nettype wire

// ==== spa_host.sv ====
// Host controller model that pulses start contacts and copies chg onto bit 0 of the request word.
`timescale 1ns/1ps
`default_nettype none
module spa_host (
  input wire logic core_clk,
  input wire logic go,
  input wire logic jump,
  input wire logic chg,
  input wire logic busy,
  input wire logic err,
  output var logic start = 1'h0,
  output var logic sp_start = 1'h0,
  output var logic [7:0] req_word = 8'h00
);
  logic go_q = 1'h0;
  logic jump_q = 1'h0;
  // Falling edge updates keep the block's sampling edge free of races.
  always @(negedge core_clk) begin
    start <= go & ~go_q & ~busy & ~err;
    sp_start <= jump & ~jump_q;
    req_word <= {7'h00, chg};
    go_q <= go;
    jump_q <= jump;
  end
endmodule // spa_host
`default_nettype wire

// ==== test_speed_point_positioning_axis.sv ====
// Self-checking bench for the speed point axis sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_speed_point_positioning_axis;
  logic core_clk = 1'h0, rst_n = 1'h0, go = 1'h0, jump = 1'h0, chg = 1'h0;
  logic oth = 1'h0, im = 1'h0, lp = 1'h0, ln = 1'h0, clr = 1'h0;
  logic last = 1'h1;
  logic rev = 1'h0;
  logic [1:0] pat = 2'h0;
  // Relative amounts, long enough to reach a constant speed zone.
  logic [15:0] mv = 16'h0040, spd = 16'h000A, axp = 16'h0014;
  wire busy, done, err, start, sps, mr;
  wire [1:0] code;
  wire [7:0] tidx, rw;
  wire [15:0] tgt, cmd, ml;
  int error_cnt = 0, total_checks = 0;
  // Free running clock; tables fix both ramp times at 4, so the step is the speed divided by 4.
  initial forever #12.5 core_clk = ~core_clk;
  spa_axis dut (.core_clk, .rst_n, .axis_positioning_start(start),
    .other_op_start(oth), .interp_mode(im),
    .speed_point_positioning_start(sps), .speed_change_req_word(rw),
    .start_table_num(8'h01),
    .tbl_pattern(pat), .tbl_last(last),
    .tbl_reverse(rev), .tbl_move(mv), .tbl_acc_time(16'h0004),
    .tbl_dec_time(16'h0004), .tbl_speed(spd), .axp_speed(axp),
    .limit_pos(lp), .limit_neg(ln), .error_clear(clr),
    .axis_busy_flag(busy), .axis_operation_done_flag(done),
    .error_notify_flag(err), .error_code(code), .table_index(tidx),
    .cmd_speed(cmd), .target_speed(tgt), .move_left(ml),
    .moving_reverse(mr));
  spa_host host (.core_clk, .go, .jump, .chg, .busy, .err, .start,
    .sp_start(sps), .req_word(rw));
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Bounded wait on busy; running out ends the run as a failure.
  task wb(input logic v);
    for (int i = 0; i < 400 && busy !== v; i++) @(negedge core_clk);
    if (busy !== v) begin
      error_cnt++;
      test_done;
    end
  endtask
  task fire;
    go <= 1'h1;
    cyc(3);
    go <= 1'h0;
  endtask
  task clr_err;
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
    cyc(1);
    `CHK(err, 1'h0)
  endtask
  task t_e;
    fire;
    `CHK(done, 1'h0)
    chg <= 1'h1;
    cyc(3);
    `CHK(tgt, 16'h000A)
    chg <= 1'h0;
    wb(1'h0);
    cyc(4);
    `CHK(done, 1'h1)
    `CHK(ml, 16'h0000)
    oth <= 1'h1;
    cyc(1);
    oth <= 1'h0;
    cyc(1);
    `CHK(done, 1'h0)
    $display("t_e end");
  endtask
  // Change requested mid ramp waits; a held level triggers nothing more.
  task t_j;
    pat <= 2'h3;
    last <= 1'h0;
    fire;
    chg <= 1'h1;
    cyc(2);
    `CHK(tgt, 16'h000A)
    cyc(20);
    `CHK(tgt, 16'h0014)
    `CHK(cmd, 16'h0014)
    `CHK(busy, 1'h1)
    axp <= 16'h001E;
    cyc(4);
    `CHK(tgt, 16'h0014)
    chg <= 1'h0;
    pat <= 2'h0;
    last <= 1'h1;
    spd <= 16'h0008;
    jump <= 1'h1;
    cyc(3);
    jump <= 1'h0;
    `CHK(tidx, 8'h02)
    `CHK(tgt, 16'h0008)
    wb(1'h0);
    `CHK(done, 1'h1)
    $display("t_j end");
  endtask
  task t_lim;
    ln <= 1'h1;
    fire;
    `CHK(code, 2'h2)
    ln <= 1'h0;
    clr_err;
    mv <= 16'h4000;
    fire;
    lp <= 1'h1;
    wb(1'h0);
    `CHK(code, 2'h2)
    lp <= 1'h0;
    clr_err;
    rev <= 1'h1;
    fire;
    ln <= 1'h1;
    wb(1'h0);
    `CHK(code, 2'h2)
    `CHK(mr, 1'h1)
    ln <= 1'h0;
    rev <= 1'h0;
    clr_err;
    $display("t_lim end");
  endtask
  task bad(input logic [1:0] p, input logic l, input logic [15:0] s,
      input logic i, input logic [1:0] c);
    pat <= p;
    last <= l;
    spd <= s;
    im <= i;
    fire;
    `CHK(busy, 1'h0)
    `CHK(code, c)
    im <= 1'h0;
    clr_err;
    $display("bad end");
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(12);
    rst_n <= 1'h1;
    t_e;
    t_j;
    t_lim;
    bad(2'h0, 1'h1, 16'h0000, 1'h0, 2'h1);
    bad(2'h0, 1'h1, 16'hFFF1, 1'h0, 2'h1);
    bad(2'h3, 1'h0, 16'h000A, 1'h1, 2'h1);
    bad(2'h1, 1'h1, 16'h000A, 1'h0, 2'h3);
    test_done;
  end
endmodule // test_speed_point_positioning_axis
bind spa_axis spa_axis_asserts chk (.core_clk, .rst_n, .axis_positioning_start,
  .other_op_start, .limit_pos, .limit_neg, .moving_reverse, .axis_busy_flag,
  .axis_operation_done_flag, .error_notify_flag, .error_code);
`default_nettype wire
